// ### hw/dac_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_decoder #(
	parameter int unsigned CH    = dac_cmd_pkg::CHANNELS,
	parameter int unsigned WIDTH = dac_cmd_pkg::VALUE_BITS
) (
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	input  wire logic                frame_sel_n,
	input  wire logic                serial_clk,
	input  wire logic                serial_din,
	output logic                     serial_dout,
	output logic [CH*WIDTH-1:0]      channel_value,
	output logic [CH*2-1:0]          channel_term,
	output logic                     bias_enable,
	output logic                     direct_update_mode
);
	if (CH != dac_cmd_pkg::CHANNELS || WIDTH != dac_cmd_pkg::VALUE_BITS) begin : g_bad_params
		$error("channel count and width are fixed by the command format");
	end

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [1:0] sclk_sync_reg;
	logic [1:0] sel_sync_reg;
	logic [1:0] din_sync_reg;
	logic       sclk_d_reg;
	logic       sel_d_reg;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			// clock parks high, so no false fall after reset
			sclk_sync_reg <= 2'h3;
			sel_sync_reg  <= 2'h3;
			din_sync_reg  <= 2'h0;
			sclk_d_reg    <= 1'b1;
			sel_d_reg     <= 1'b1;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], serial_clk};
			sel_sync_reg  <= {sel_sync_reg[0], frame_sel_n};
			din_sync_reg  <= {din_sync_reg[0], serial_din};
			sclk_d_reg    <= sclk_sync_reg[1];
			sel_d_reg     <= sel_sync_reg[1];
		end
	end

	logic sclk_fall;
	logic sel_rise;
	logic sel_low;
	assign sclk_fall = sclk_d_reg & ~sclk_sync_reg[1];
	assign sel_rise  = ~sel_d_reg & sel_sync_reg[1];
	assign sel_low   = ~sel_sync_reg[1];

	// ---------------------------------------------------------------
	// frame shifting
	// ---------------------------------------------------------------
	logic [15:0]                   shift_reg;
	logic [15:0]                   chain_reg;
	logic [dac_cmd_pkg::CNT_BITS-1:0] edge_cnt_reg;
	logic [dac_cmd_pkg::CNT_BITS-1:0] edge_cnt_next;

	// counter saturates; the chain only needs to know we are past fifteen
	assign edge_cnt_next = (edge_cnt_reg == '1) ? edge_cnt_reg
		: edge_cnt_reg + dac_cmd_pkg::CNT_BITS'(1);

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			edge_cnt_reg <= '0;
		end else if (!sel_low) begin
			edge_cnt_reg <= '0;
		end else if (sclk_fall) begin
			edge_cnt_reg <= edge_cnt_next;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg <= 16'h0000;
		end else if (!sel_low) begin
			shift_reg <= 16'h0000;
		end else if (sclk_fall) begin
			shift_reg <= {shift_reg[14:0], din_sync_reg[1]};
		end
	end

	// separate delay line so the first sixteen input bits come out in order
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			chain_reg <= 16'h0000;
		end else if (!sel_low) begin
			chain_reg <= 16'h0000;
		end else if (sclk_fall) begin
			chain_reg <= {chain_reg[14:0], din_sync_reg[1]};
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			serial_dout <= 1'b0;
		end else if (!sel_low) begin
			serial_dout <= 1'b0;
		end else if (sclk_fall) begin
			if (edge_cnt_next < dac_cmd_pkg::CNT_BITS'(dac_cmd_pkg::DOUT_HIGH_EDGE))
				serial_dout <= 1'b0;
			else if (edge_cnt_next == dac_cmd_pkg::CNT_BITS'(dac_cmd_pkg::DOUT_HIGH_EDGE))
				serial_dout <= 1'b1;
			else
				// first input bit sits at fourteen by the sixteenth fall
				serial_dout <= chain_reg[dac_cmd_pkg::FRAME_BITS - 2];
		end
	end

	// ---------------------------------------------------------------
	// command decode on select rising edge
	// ---------------------------------------------------------------
	logic             exec;
	logic [3:0]       opcode_field;
	logic [2:0]       channel_select_field;
	logic [WIDTH-1:0] value_field;
	logic [CH-1:0]    channel_mask_field;

	// frames of under fifteen falls executed nothing; the last sixteen bits hold our command
	assign exec = sel_rise
		&& edge_cnt_reg >= dac_cmd_pkg::CNT_BITS'(dac_cmd_pkg::ABORT_EDGE);
	assign opcode_field = shift_reg[dac_cmd_pkg::OPCODE_MSB:dac_cmd_pkg::OPCODE_LSB];
	assign channel_select_field = shift_reg[dac_cmd_pkg::CHSEL_MSB:dac_cmd_pkg::CHSEL_LSB];
	assign value_field = shift_reg[dac_cmd_pkg::VALUE_MSB:dac_cmd_pkg::VALUE_LSB];
	assign channel_mask_field = shift_reg[dac_cmd_pkg::MASK_MSB:dac_cmd_pkg::MASK_LSB];

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			direct_update_mode <= 1'b0;
		end else if (exec && opcode_field == dac_cmd_pkg::OP_DIRECT) begin
			direct_update_mode <= 1'b1;
		end else if (exec && opcode_field == dac_cmd_pkg::OP_STAGED) begin
			direct_update_mode <= 1'b0;
		end
	end

	logic [CH-1:0]    reg_we;
	logic [CH-1:0]    out_upd;
	logic [CH-1:0]    pd_set;
	logic [1:0]       pd_term;
	logic [WIDTH-1:0] reg_din;

	always_comb begin
		reg_we  = '0;
		out_upd = '0;
		pd_set  = '0;
		pd_term = dac_cmd_pkg::TERM_ACTIVE;
		reg_din = value_field;
		if (exec) begin
			if (!opcode_field[3]) begin
				reg_we[channel_select_field] = 1'b1;
				out_upd[channel_select_field] = direct_update_mode;
			end else begin
				case (opcode_field)
					dac_cmd_pkg::OP_UPD_SEL: begin
						out_upd = channel_mask_field;
					end
					dac_cmd_pkg::OP_CHA_WRITE: begin
						reg_we[0] = 1'b1;
						out_upd   = '1;
					end
					dac_cmd_pkg::OP_BROADCAST: begin
						reg_we  = '1;
						out_upd = '1;
					end
					dac_cmd_pkg::OP_PD_HIZ: begin
						pd_set  = channel_mask_field;
						pd_term = dac_cmd_pkg::TERM_HIZ;
					end
					dac_cmd_pkg::OP_PD_100K: begin
						pd_set  = channel_mask_field;
						pd_term = dac_cmd_pkg::TERM_100K;
					end
					dac_cmd_pkg::OP_PD_2K5: begin
						pd_set  = channel_mask_field;
						pd_term = dac_cmd_pkg::TERM_2K5;
					end
					default: begin
						pd_set = '0;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// channels
	// ---------------------------------------------------------------
	logic [CH*WIDTH-1:0] data_all;
	logic [CH*2-1:0]     term_all;

	for (genvar i = 0; i < CH; i++) begin : g_ch
		dac_channel #(.WIDTH(WIDTH)) u_ch (
			.ref_clk  (ref_clk),
			.reset_n  (reset_n),
			.reg_we   (reg_we[i]),
			.reg_din  (reg_din),
			.out_upd  (out_upd[i]),
			.pd_set   (pd_set[i]),
			.pd_term  (pd_term),
			.data_reg (data_all[i*WIDTH +: WIDTH]),
			.out_reg  (channel_value[i*WIDTH +: WIDTH]),
			.term_reg (term_all[i*2 +: 2])
		);
	end
	assign channel_term = term_all;

	logic [CH-1:0] awake;
	for (genvar i = 0; i < CH; i++) begin : g_awake
		assign awake[i] = (term_all[i*2 +: 2] == dac_cmd_pkg::TERM_ACTIVE);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bias_enable <= 1'b1;
		end else begin
			bias_enable <= |awake;
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_mode_direct: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && opcode_field == dac_cmd_pkg::OP_DIRECT |=> direct_update_mode)
		else $error("direct code did not set direct mode");
	a_mode_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && opcode_field[3] && opcode_field[3:1] != 3'h4 |=> $stable(direct_update_mode))
		else $error("special command changed mode");
	a_abort_short: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sel_rise && edge_cnt_reg < 6'h0f |=> $stable(channel_value) && $stable(channel_term))
		else $error("aborted frame changed state");
	a_dout_low: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sel_low && edge_cnt_reg < 6'h0e && !sclk_fall |-> !serial_dout)
		else $error("serial out high before edge fifteen");
	sequence s_edge15;
		sel_low && sclk_fall && edge_cnt_reg == 6'h0e;
	endsequence
	a_dout_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
		s_edge15 |=> serial_dout)
		else $error("serial out not high at edge fifteen");
	a_dout_chain: assert property (@(posedge ref_clk) disable iff (!reset_n)
		sel_low && sclk_fall && edge_cnt_reg >= 6'h0f && edge_cnt_reg < 6'h1e
		|=> serial_dout == $past(chain_reg[14]))
		else $error("chained bit out of order");
	a_staged_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && !opcode_field[3] && !direct_update_mode |=> $stable(channel_value))
		else $error("staged write moved an output");
	a_broadcast: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && opcode_field == dac_cmd_pkg::OP_BROADCAST
		|=> channel_value == {CH{$past(value_field)}})
		else $error("broadcast did not reach all outputs");
	a_bias_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
		term_all != '0 && awake == '0 |=> !bias_enable)
		else $error("bias on with all channels down");
	a_dout_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!sel_low |=> !serial_dout)
		else $error("serial out high outside a frame");
	a_cha_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && opcode_field == dac_cmd_pkg::OP_CHA_WRITE |=> channel_value[WIDTH-1:0] == $past(value_field))
		else $error("channel a write did not reach its output");
	a_wake_all: assert property (@(posedge ref_clk) disable iff (!reset_n)
		exec && (opcode_field == dac_cmd_pkg::OP_CHA_WRITE || opcode_field == dac_cmd_pkg::OP_BROADCAST)
		|=> awake == '1)
		else $error("full update left a channel powered down");
	for (genvar i = 0; i < CH; i++) begin : g_chk
		a_upd_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
			exec && opcode_field == dac_cmd_pkg::OP_UPD_SEL && channel_mask_field[i]
			|=> channel_value[i*WIDTH +: WIDTH] == $past(data_all[i*WIDTH +: WIDTH]) && awake[i])
			else $error("update select missed a channel");
		a_pd_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
			exec && opcode_field >= dac_cmd_pkg::OP_PD_HIZ && channel_mask_field[i]
			|=> term_all[i*2 +: 2] == $past(opcode_field[1:0]) && $stable(data_all[i*WIDTH +: WIDTH]))
			else $error("power down term wrong or register lost");
		a_direct_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
			exec && !opcode_field[3] && direct_update_mode && channel_select_field == 3'(i)
			|=> channel_value[i*WIDTH +: WIDTH] == $past(value_field) && awake[i])
			else $error("direct write did not reach its output");
	end
endmodule
`default_nettype wire

// ### hw/dac_cmd_pkg.sv
package dac_cmd_pkg;
	// ---------------------------------------------------------------
	// frame geometry
	// ---------------------------------------------------------------
	localparam int unsigned FRAME_BITS    = 16;
	localparam int unsigned ABORT_EDGE    = 15;
	localparam int unsigned DOUT_HIGH_EDGE = 15;
	localparam int unsigned CHANNELS      = 8;
	localparam int unsigned VALUE_BITS    = 10;
	localparam int unsigned CNT_BITS      = 6;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int unsigned OPCODE_MSB    = 15;
	localparam int unsigned OPCODE_LSB    = 12;
	localparam int unsigned CHSEL_MSB     = 14;
	localparam int unsigned CHSEL_LSB     = 12;
	localparam int unsigned VALUE_MSB     = 11;
	localparam int unsigned VALUE_LSB     = 2;
	localparam int unsigned MASK_MSB      = 7;
	localparam int unsigned MASK_LSB      = 0;
	// ---------------------------------------------------------------
	// opcodes (bit 15 clear means channel write)
	// ---------------------------------------------------------------
	localparam logic [3:0] OP_STAGED      = 4'h8;
	localparam logic [3:0] OP_DIRECT      = 4'h9;
	localparam logic [3:0] OP_UPD_SEL     = 4'ha;
	localparam logic [3:0] OP_CHA_WRITE   = 4'hb;
	localparam logic [3:0] OP_BROADCAST   = 4'hc;
	localparam logic [3:0] OP_PD_HIZ      = 4'hd;
	localparam logic [3:0] OP_PD_100K     = 4'he;
	localparam logic [3:0] OP_PD_2K5      = 4'hf;
	// ---------------------------------------------------------------
	// output termination codes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		TERM_ACTIVE = 2'h0,
		TERM_HIZ    = 2'h1,
		TERM_100K   = 2'h2,
		TERM_2K5    = 2'h3
	} term_t;
	localparam logic [9:0] VALUE_RESET    = 10'h000;
endpackage

// ### hw/dac_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dac_channel #(
	parameter int unsigned WIDTH = 10
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic             reg_we,
	input  wire logic [WIDTH-1:0] reg_din,
	input  wire logic             out_upd,
	input  wire logic             pd_set,
	input  wire logic [1:0]       pd_term,
	output logic      [WIDTH-1:0] data_reg,
	output logic      [WIDTH-1:0] out_reg,
	output logic      [1:0]       term_reg
);
	if (WIDTH < 1) begin : g_bad_width
		$error("channel width must be at least one bit");
	end
	// ---------------------------------------------------------------
	// data register, output latch, termination
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_reg <= '0;
		end else if (reg_we) begin
			data_reg <= reg_din;
		end
	end

	// output takes the new value in the same cycle as the register write
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= '0;
		end else if (out_upd) begin
			out_reg <= reg_we ? reg_din : data_reg;
		end
	end

	// power-down leaves data_reg alone; an output update wakes it
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			term_reg <= dac_cmd_pkg::TERM_ACTIVE;
		end else if (pd_set) begin
			term_reg <= pd_term;
		end else if (out_upd) begin
			term_reg <= dac_cmd_pkg::TERM_ACTIVE;
		end
	end
endmodule
`default_nettype wire

// ### sim/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
	input  wire logic ref_clk,
	input  wire logic serial_dout,
	output var  logic frame_sel_n,
	output var  logic serial_clk,
	output var  logic serial_din
);
	// ---------------------------------------------------------------
	// frame driver, 400 ns clock, clock parked high between frames
	// ---------------------------------------------------------------
	logic [31:0] cap;
	initial begin
		frame_sel_n = 1'b1;
		serial_clk  = 1'b1;
		serial_din  = 1'b0;
		cap         = 32'h0;
	end
	// bits[n-1] goes first; n is a multiple of sixteen for a chain
	task automatic send(input logic [31:0] bits, input int n);
		@(negedge ref_clk);
		frame_sel_n = 1'b0;
		for (int k = n - 1; k >= 0; k--) begin
			// din moves while clock high, half a period before the fall
			serial_din = bits[k];
			#200;
			serial_clk = 1'b0;
			#200;
			cap[n-1-k] = serial_dout;
			serial_clk = 1'b1;
		end
		#200;
		frame_sel_n = 1'b1;
		// released line: inverse of last bit, not a stale copy
		serial_din = ~serial_din;
		#400;
	endtask
endmodule
`default_nettype wire

// ### sim/tb_dac_cmd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dac_cmd_decoder;
	// ---------------------------------------------------------------
	// signals and expected state
	// ---------------------------------------------------------------
	logic        ref_clk;
	logic        reset_n;
	wire logic   frame_sel_n;
	wire logic   serial_clk;
	wire logic   serial_din;
	logic        serial_dout;
	logic [79:0] channel_value;
	logic [15:0] channel_term;
	logic        bias_enable;
	logic        direct_update_mode;
	logic [9:0]  d_m [8];
	logic [9:0]  o_m [8];
	logic [1:0]  t_m [8];
	logic        mode_m;
	int          n_mismatch;
	int          num_checks;
	int          seed;
	logic [15:0] w1;
	logic [15:0] w2;
	dac_cmd_decoder u_dac_cmd_decoder (
		.ref_clk            (ref_clk),
		.reset_n            (reset_n),
		.frame_sel_n        (frame_sel_n),
		.serial_clk         (serial_clk),
		.serial_din         (serial_din),
		.serial_dout        (serial_dout),
		.channel_value      (channel_value),
		.channel_term       (channel_term),
		.bias_enable        (bias_enable),
		.direct_update_mode (direct_update_mode)
	);
	serial_host u_host (
		.ref_clk     (ref_clk),
		.serial_dout (serial_dout),
		.frame_sel_n (frame_sel_n),
		.serial_clk  (serial_clk),
		.serial_din  (serial_din)
	);
	initial ref_clk = 1'b0;
	always #25 ref_clk = ~ref_clk;
	// ---------------------------------------------------------------
	// expectation
	// ---------------------------------------------------------------
	function automatic logic [15:0] rnd16();
		return 16'($random(seed));
	endfunction
	function automatic logic [30:0] exp_dout(input logic [15:0] w);
		logic [30:0] e;
		e = 31'h4000;
		for (int m = 0; m < 16; m++) e[15+m] = w[15-m];
		return e;
	endfunction
	task automatic model(input logic [15:0] c);
		logic [9:0] v;
		v = c[11:2];
		case (c[15:12])
			dac_cmd_pkg::OP_STAGED: mode_m = 1'b0;
			dac_cmd_pkg::OP_DIRECT: mode_m = 1'b1;
			dac_cmd_pkg::OP_UPD_SEL: begin
				for (int i = 0; i < 8; i++) if (c[i]) begin
					o_m[i] = d_m[i];
					t_m[i] = 2'h0;
				end
			end
			dac_cmd_pkg::OP_CHA_WRITE, dac_cmd_pkg::OP_BROADCAST: begin
				for (int i = 0; i < 8; i++) begin
					if (i == 0 || c[14]) d_m[i] = v;
					o_m[i] = d_m[i];
					t_m[i] = 2'h0;
				end
			end
			dac_cmd_pkg::OP_PD_HIZ, dac_cmd_pkg::OP_PD_100K, dac_cmd_pkg::OP_PD_2K5: begin
				for (int i = 0; i < 8; i++) if (c[i]) t_m[i] = c[13:12];
			end
			default: begin
				d_m[c[14:12]] = v;
				if (mode_m) begin
					o_m[c[14:12]] = v;
					t_m[c[14:12]] = 2'h0;
				end
			end
		endcase
	endtask
	// ---------------------------------------------------------------
	// compares
	// ---------------------------------------------------------------
	task automatic check_out();
		logic ok;
		logic bias;
		bias = 1'b0;
		for (int i = 0; i < 8; i++) bias |= (t_m[i] == 2'h0);
		ok = (direct_update_mode === mode_m) && (bias_enable === bias);
		// a powered-down channel's value is not looked at
		for (int i = 0; i < 8; i++) begin
			ok &= (channel_term[2*i+:2] === t_m[i]);
			ok &= (t_m[i] != 2'h0) || (channel_value[10*i+:10] === o_m[i]);
		end
		num_checks++;
		if (!ok) begin
			n_mismatch++;
			$display("MISMATCH %0t outputs differ", $time);
		end
	endtask
	task automatic check_dout(input logic [15:0] w);
		num_checks++;
		if (u_host.cap[30:0] !== exp_dout(w)) begin
			n_mismatch++;
			$display("MISMATCH %0t chain output %h", $time, u_host.cap[30:0]);
		end
	endtask
	task automatic cmd(input logic [15:0] c);
		u_host.send({16'h0, c}, 16);
		model(c);
		check_out();
	endtask
	task automatic init_model();
		mode_m = 1'b0;
		for (int i = 0; i < 8; i++) begin
			d_m[i] = 10'h0;
			o_m[i] = 10'h0;
			t_m[i] = 2'h0;
		end
	endtask
	task automatic summarize();
		if (n_mismatch == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		seed = 32'h350a;
		reset_n = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		init_model();
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check_out();
		for (int i = 0; i < 8; i++) cmd({1'b0, 3'(i), 12'(rnd16()) | 12'h003});
		cmd(16'ha000 | (rnd16() & 16'h00ff));
		cmd(16'h9000 | (rnd16() & 16'h0fff));
		cmd(rnd16() & 16'h7fff);
		cmd(16'ha0ff);
		cmd(16'hc000 | (rnd16() & 16'h0fff));
		cmd(16'h8000);
		cmd(rnd16() & 16'h7fff);
		cmd(16'hb000 | (rnd16() & 16'h0fff));
		for (int op = 13; op < 16; op++) cmd({4'(op), 4'h0, 8'(rnd16())});
		cmd(16'hd0ff);
		cmd(rnd16() & 16'h7fff);
		cmd(16'hb000 | (rnd16() & 16'h0fff));
		u_host.send({16'h0, rnd16()}, 14);
		check_out();
		w1 = rnd16();
		u_host.send({17'h0, w1[14:0]}, 15);
		model({1'b0, w1[14:0]});
		check_out();
		w1 = rnd16();
		w2 = rnd16();
		u_host.send({w1, w2}, 32);
		model(w2);
		check_out();
		check_dout(w1);
		for (int k = 0; k < 24; k++) cmd(rnd16());
		@(negedge ref_clk);
		reset_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		reset_n = 1'b1;
		init_model();
		repeat (4) @(negedge ref_clk);
		check_out();
		cmd(rnd16() & 16'h7fff);
		summarize();
	end
	initial begin
		#2000000;
		n_mismatch++;
		summarize();
	end
endmodule
`default_nettype wire
